// ===== core/cas_pkg.sv
// Constants for the clock alarm status and interrupt block
// Contract
// - Internal status bit 0 is high while the device calibrates.
// - Internal status bit 1 is high when the reference oscillator pins lose signal.
// - Internal status bit 5 is high on a serial-bus timeout.
// - Input alarm register shows live loss bits 1:0 and frequency bits 5:4.
// - Lock status bit 1 shows live PLL loss of lock.
// - Lock status bit 5 shows live holdover or free-run.
// - Calibration status bit 5 shows live PLL calibration busy.
// - Sticky fault bits 0, 1, 5 latch their live conditions until cleared.
// - Writing zero clears only those sticky bits; ones leave bits unchanged.
// - Sticky alarm bits 1:0 and 5:4 latch per input, cleared by zero.
// - Sticky lock bits 1 and 5 latch unlock and holdover, cleared by zero.
// - Sticky calibration bit 5 latches PLL busy, cleared by writing zero.
// - Fault mask bits 0, 1, 5 gate sticky fault flags from interrupt.
// - Alarm mask bits 1:0 and 5:4 gate sticky input flags.
// - Lock mask bit 1 gates unlock flag, bit 5 gates holdover flag.
// - Mask one blocks the flag; mask zero lets a set flag interrupt.
// - Interrupt pin is active low; reference loss reaches it unless masked.
// - Calibration mask bit 5 gates the sticky PLL calibration flag.
package cas_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CAS_OFS_FAULT_STAT  = 8'h0c;
    localparam logic [7:0] CAS_OFS_ALARM_STAT  = 8'h0d;
    localparam logic [7:0] CAS_OFS_LOCK_STAT   = 8'h0e;
    localparam logic [7:0] CAS_OFS_CAL_STAT    = 8'h0f;
    localparam logic [7:0] CAS_OFS_FAULT_STKY  = 8'h11;
    localparam logic [7:0] CAS_OFS_ALARM_STKY  = 8'h12;
    localparam logic [7:0] CAS_OFS_LOCK_STKY   = 8'h13;
    localparam logic [7:0] CAS_OFS_CAL_STKY    = 8'h14;
    localparam logic [7:0] CAS_OFS_FAULT_MASK  = 8'h17;
    localparam logic [7:0] CAS_OFS_ALARM_MASK  = 8'h18;
    localparam logic [7:0] CAS_OFS_LOCK_MASK   = 8'h19;
    localparam logic [7:0] CAS_OFS_CAL_MASK    = 8'h1a;
    // ------------------------------------------------------------
    // Implemented bit sets per register (other bits read zero)
    // ------------------------------------------------------------
    localparam logic [7:0] CAS_FAULT_BITS = 8'h23;   // Bits 0, 1, 5
    localparam logic [7:0] CAS_ALARM_BITS = 8'h33;   // Bits 1:0, 5:4
    localparam logic [7:0] CAS_LOCK_BITS  = 8'h22;   // Bits 1, 5
    localparam logic [7:0] CAS_CAL_BITS   = 8'h20;   // Bit 5
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CAS_POS_CALIBRATING = 0;
    localparam int CAS_POS_REF_LOSS    = 1;
    localparam int CAS_POS_BUS_TIMEOUT = 5;
    localparam int CAS_POS_LOS_LO      = 0;
    localparam int CAS_POS_OOF_LO      = 4;
    localparam int CAS_POS_UNLOCK      = 1;
    localparam int CAS_POS_HOLDOVER    = 5;
    localparam int CAS_POS_PLL_CAL     = 5;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CAS_STKY_RST = 8'h00;
    localparam logic [7:0] CAS_MASK_RST = 8'h00;
endpackage : cas_pkg

// ===== core/cas_sticky_group.sv
// One sticky flag register with its mask and interrupt term
`timescale 1ns/1ps
`default_nettype none
module cas_sticky_group
    import cas_pkg::*;
#(
    parameter logic [7:0] BITS = 8'hff
)(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] live,
    input  wire logic       stky_wr,
    input  wire logic       mask_wr,
    input  wire logic [7:0] wr_data,
    output var  logic [7:0] stky_q,
    output var  logic [7:0] mask_q,
    output logic            irq_term
);
    logic [7:0] stky_r;
    logic [7:0] stky_nxt;
    logic [7:0] mask_r;
    logic [7:0] mask_nxt;
    wire  [7:0] clr_bits = stky_wr ? ~wr_data : 8'h00;

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    // A live event in the clear cycle wins, so no event is lost
    assign stky_nxt = ((stky_r & ~clr_bits) | live) & BITS;
    assign mask_nxt = mask_wr ? (wr_data & BITS) : mask_r;
    // Mask one blocks, mask zero passes a set flag
    assign irq_term = |(stky_r & ~mask_r & BITS);

    // Flag and mask storage
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stky_r <= CAS_STKY_RST;
            mask_r <= CAS_MASK_RST;
        end
        else
        begin
            stky_r <= stky_nxt;
            mask_r <= mask_nxt;
        end
    end

    assign stky_q = stky_r;
    assign mask_q = mask_r;
endmodule : cas_sticky_group
`default_nettype wire

// ===== core/cas_status_irq.sv
// Status, sticky flag and interrupt mask top for the clock alarm block
`timescale 1ns/1ps
`default_nettype none
module cas_status_irq
    import cas_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // Live conditions from the rest of the device
    input  wire logic       device_calibrating,
    input  wire logic       ref_pin_signal_loss,
    input  wire logic       bus_timeout,
    input  wire logic [1:0] loss_of_signal,
    input  wire logic [1:0] out_of_frequency,
    input  wire logic       loss_of_lock,
    input  wire logic       pll_holdover,
    input  wire logic       pll_cal_busy,
    // Register port from the serial interface
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output var  logic [7:0] reg_rdata,
    // Interrupt pin, active low
    output var  logic       irq_out_n
);
    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n_r;

    // Release is synchronous so flags never leave reset on a split edge
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------
    // Live status words
    // ------------------------------------------------------------
    wire [7:0] fault_live;
    wire [7:0] alarm_live;
    wire [7:0] lock_live;
    wire [7:0] cal_live;

    assign fault_live = (8'(device_calibrating)  << CAS_POS_CALIBRATING)
                      | (8'(ref_pin_signal_loss) << CAS_POS_REF_LOSS)
                      | (8'(bus_timeout)         << CAS_POS_BUS_TIMEOUT);
    // Input 0 lands on bits 0 and 4, input 1 on bits 1 and 5
    assign alarm_live = (8'(loss_of_signal)   << CAS_POS_LOS_LO)
                      | (8'(out_of_frequency) << CAS_POS_OOF_LO);
    assign lock_live  = (8'(loss_of_lock) << CAS_POS_UNLOCK)
                      | (8'(pll_holdover) << CAS_POS_HOLDOVER);
    assign cal_live   = 8'(pll_cal_busy) << CAS_POS_PLL_CAL;

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    wire wr_fault_stky = reg_wr && (reg_addr == CAS_OFS_FAULT_STKY);
    wire wr_alarm_stky = reg_wr && (reg_addr == CAS_OFS_ALARM_STKY);
    wire wr_lock_stky  = reg_wr && (reg_addr == CAS_OFS_LOCK_STKY);
    wire wr_cal_stky   = reg_wr && (reg_addr == CAS_OFS_CAL_STKY);
    wire wr_fault_mask = reg_wr && (reg_addr == CAS_OFS_FAULT_MASK);
    wire wr_alarm_mask = reg_wr && (reg_addr == CAS_OFS_ALARM_MASK);
    wire wr_lock_mask  = reg_wr && (reg_addr == CAS_OFS_LOCK_MASK);
    wire wr_cal_mask   = reg_wr && (reg_addr == CAS_OFS_CAL_MASK);

    // ------------------------------------------------------------
    // Sticky groups
    // ------------------------------------------------------------
    wire [7:0] fault_stky;
    wire [7:0] fault_mask;
    wire [7:0] alarm_stky;
    wire [7:0] alarm_mask;
    wire [7:0] lock_stky;
    wire [7:0] lock_mask;
    wire [7:0] cal_stky;
    wire [7:0] cal_mask;
    wire [3:0] irq_terms;

    // Fault flags and their masks
    cas_sticky_group #(.BITS(CAS_FAULT_BITS)) u_fault (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n_r),
        .live     (fault_live),
        .stky_wr  (wr_fault_stky),
        .mask_wr  (wr_fault_mask),
        .wr_data  (reg_wdata),
        .stky_q   (fault_stky),
        .mask_q   (fault_mask),
        .irq_term (irq_terms[0])
    );

    // Per-input alarm flags and their masks
    cas_sticky_group #(.BITS(CAS_ALARM_BITS)) u_alarm (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n_r),
        .live     (alarm_live),
        .stky_wr  (wr_alarm_stky),
        .mask_wr  (wr_alarm_mask),
        .wr_data  (reg_wdata),
        .stky_q   (alarm_stky),
        .mask_q   (alarm_mask),
        .irq_term (irq_terms[1])
    );

    // Lock and holdover flags and their masks
    cas_sticky_group #(.BITS(CAS_LOCK_BITS)) u_lock (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n_r),
        .live     (lock_live),
        .stky_wr  (wr_lock_stky),
        .mask_wr  (wr_lock_mask),
        .wr_data  (reg_wdata),
        .stky_q   (lock_stky),
        .mask_q   (lock_mask),
        .irq_term (irq_terms[2])
    );

    // PLL calibration flag and its mask
    cas_sticky_group #(.BITS(CAS_CAL_BITS)) u_cal (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n_r),
        .live     (cal_live),
        .stky_wr  (wr_cal_stky),
        .mask_wr  (wr_cal_mask),
        .wr_data  (reg_wdata),
        .stky_q   (cal_stky),
        .mask_q   (cal_mask),
        .irq_term (irq_terms[3])
    );

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [7:0] rdata_nxt;

    // Unmapped offsets read zero; the read has no side effect
    always_comb
    begin
        case (reg_addr)
            CAS_OFS_FAULT_STAT: rdata_nxt = fault_live;
            CAS_OFS_ALARM_STAT: rdata_nxt = alarm_live;
            CAS_OFS_LOCK_STAT:  rdata_nxt = lock_live;
            CAS_OFS_CAL_STAT:   rdata_nxt = cal_live;
            CAS_OFS_FAULT_STKY: rdata_nxt = fault_stky;
            CAS_OFS_ALARM_STKY: rdata_nxt = alarm_stky;
            CAS_OFS_LOCK_STKY:  rdata_nxt = lock_stky;
            CAS_OFS_CAL_STKY:   rdata_nxt = cal_stky;
            CAS_OFS_FAULT_MASK: rdata_nxt = fault_mask;
            CAS_OFS_ALARM_MASK: rdata_nxt = alarm_mask;
            CAS_OFS_LOCK_MASK:  rdata_nxt = lock_mask;
            CAS_OFS_CAL_MASK:   rdata_nxt = cal_mask;
            default:            rdata_nxt = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    wire irq_nxt_n = ~(|irq_terms);

    // Registered so the pin never glitches on mux settling
    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            reg_rdata <= 8'h00;
            irq_out_n <= 1'b1;
        end
        else
        begin
            reg_rdata <= rdata_nxt;
            irq_out_n <= irq_nxt_n;
        end
    end
endmodule : cas_status_irq
`default_nettype wire

// ===== test/cas_status_irq_asserts.sv
// Port-level checks for the alarm status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module cas_status_irq_asserts
    import cas_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       nrst,
    input wire logic       device_calibrating,
    input wire logic       ref_pin_signal_loss,
    input wire logic       bus_timeout,
    input wire logic [1:0] loss_of_signal,
    input wire logic [1:0] out_of_frequency,
    input wire logic       loss_of_lock,
    input wire logic       pll_holdover,
    input wire logic       pll_cal_busy,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       irq_out_n
);
    logic [1:0] up_r;
    logic       lk_msk_r;
    logic       any_live;
    // Checks sleep until the two-flop reset release has run out
    always_ff @(posedge sys_clk or negedge nrst)
        if (!nrst) up_r <= 2'h0;
        else if (up_r != 2'h3) up_r <= up_r + 2'h1;
    // Shadow of the unlock mask bit, so the irq check knows it is open
    always_ff @(posedge sys_clk or negedge nrst)
        if (!nrst) lk_msk_r <= 1'b0;
        else if (reg_wr && reg_addr == CAS_OFS_LOCK_MASK) lk_msk_r <= reg_wdata[1];
    assign any_live = device_calibrating | ref_pin_signal_loss | bus_timeout | pll_cal_busy
        | (|loss_of_signal) | (|out_of_frequency) | loss_of_lock | pll_holdover;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (up_r != 2'h3);
    a_fault_live: assert property (reg_addr == CAS_OFS_FAULT_STAT |=>
        reg_rdata == {2'h0, $past(bus_timeout), 3'h0, $past(ref_pin_signal_loss),
        $past(device_calibrating)}) else $error("fault status wrong");
    a_alarm_live: assert property (reg_addr == CAS_OFS_ALARM_STAT |=>
        reg_rdata == {2'h0, $past(out_of_frequency), 2'h0, $past(loss_of_signal)})
        else $error("alarm status wrong");
    a_lock_live: assert property (reg_addr == CAS_OFS_LOCK_STAT |=>
        reg_rdata == {2'h0, $past(pll_holdover), 3'h0, $past(loss_of_lock), 1'h0})
        else $error("lock status wrong");
    a_cal_live: assert property (reg_addr == CAS_OFS_CAL_STAT |=>
        reg_rdata == {2'h0, $past(pll_cal_busy), 5'h0}) else $error("cal status wrong");
    a_unlock_sticky: assert property (loss_of_lock ##1 reg_addr == CAS_OFS_LOCK_STKY
        |=> reg_rdata[1]) else $error("unlock not latched");
    // Pin is a flop behind the flags, so its cause lies two edges back
    a_irq_rise: assert property ($rose(irq_out_n) |-> $past(reg_wr, 2))
        else $error("irq released without a write");
    a_irq_fall: assert property ($fell(irq_out_n) |->
        $past(any_live, 2) || $past(reg_wr, 2)) else $error("irq raised without cause");
    a_unlock_irq: assert property (loss_of_lock && !lk_msk_r &&
        !(reg_wr && reg_addr == CAS_OFS_LOCK_MASK) |=> ##1 !irq_out_n) else $error("unlock irq");
    a_unmapped_zero: assert property (reg_addr == 8'h10 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    c_irq_low: cover property ($fell(irq_out_n));
    c_sticky_clr: cover property (reg_wr && reg_addr == CAS_OFS_ALARM_STKY);
    c_mask_all: cover property (reg_wr && reg_addr == CAS_OFS_FAULT_MASK && reg_wdata == 8'hff);
endmodule : cas_status_irq_asserts
bind cas_status_irq cas_status_irq_asserts u_cas_status_irq_asserts (.*);
`default_nettype wire

// ===== test/cas_host_model.sv
// Host model driving the register port of the alarm block
`timescale 1ns/1ps
`default_nettype none
module cas_host_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    output var  logic [7:0] reg_addr,
    output var  logic       reg_wr,
    output var  logic [7:0] reg_wdata
);
    // Park on an unmapped offset so idle reads are harmless
    initial
    begin
        reg_addr  = 8'h10;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
    end
    // One strobe; zero bits clear flags, one bits leave them
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge sys_clk);
        reg_wr    = 1'b0;
        reg_wdata = ~d;    // Stale data not left on the bus
    endtask : wr
    // Answer is registered, so take it one cycle after the offset
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask : rd
endmodule : cas_host_model
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the alarm status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import cas_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        nrst    = 1'b0;
    logic [9:0]  live    = 10'h000;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic        reg_wr, irq_out_n;
    int          n_mismatch = 0;
    int          checked    = 0;
    int          cyc        = 0;
    // Rows: live conditions, offset, expected read
    logic [25:0] rows [15] = '{{10'h001, 8'h0c, 8'h01}, {10'h002, 8'h0c, 8'h02},
        {10'h004, 8'h0c, 8'h20}, {10'h008, 8'h0d, 8'h01}, {10'h010, 8'h0d, 8'h02},
        {10'h020, 8'h0d, 8'h10}, {10'h040, 8'h0d, 8'h20}, {10'h080, 8'h0e, 8'h02},
        {10'h100, 8'h0e, 8'h20}, {10'h200, 8'h0f, 8'h20}, {10'h3ff, 8'h0c, 8'h23},
        {10'h3ff, 8'h0d, 8'h33}, {10'h000, 8'h0e, 8'h00}, {10'h3ff, 8'h10, 8'h00},
        {10'h3ff, 8'h1b, 8'h00}};
    logic [7:0]  m_ofs [4] = '{8'h17, 8'h18, 8'h19, 8'h1a};
    logic [7:0]  m_exp [4] = '{8'h23, 8'h33, 8'h22, 8'h20};
    always #2 sys_clk = ~sys_clk;
    cas_host_model u_cas_host_model (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata));
    cas_status_irq u_cas_status_irq (.sys_clk(sys_clk), .nrst(nrst),
        .device_calibrating(live[0]), .ref_pin_signal_loss(live[1]), .bus_timeout(live[2]),
        .loss_of_signal(live[4:3]), .out_of_frequency(live[6:5]), .loss_of_lock(live[7]),
        .pll_holdover(live[8]), .pll_cal_busy(live[9]), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_out_n(irq_out_n));
    task automatic tally_and_finish;
        if (n_mismatch == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    // Register read compared against its expected value
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] g;
        u_cas_host_model.rd(a, g);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] reg %h expected %h seen %h", a, e, g);
        end
    endtask : rdc
    // Pin level, given two cycles so the registered irq has landed
    task automatic chk_irq(input logic e);
        repeat (2) @(negedge sys_clk);
        checked++;
        if (irq_out_n !== e)
        begin
            n_mismatch++;
            $display("[ERR] irq_out_n expected %b seen %b", e, irq_out_n);
        end
    endtask : chk_irq
    // Hang guard, far above the roughly 145 cycles the run needs
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (2) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk_irq(1'b1);
        for (int i = 0; i < 15; i++)
        begin
            live = rows[i][25:16];
            rdc(rows[i][15:8], rows[i][7:0]);
        end
        live = 10'h000;
        chk_irq(1'b0);
        rdc(8'h11, 8'h23);
        rdc(8'h12, 8'h33);
        live = 10'h080;                                      // Unlock held into the sticky read
        rdc(8'h13, 8'h22);
        live = 10'h000;
        u_cas_host_model.wr(8'h12, 8'hfe);
        rdc(8'h12, 8'h32);
        u_cas_host_model.wr(8'h14, 8'hdf);
        rdc(8'h14, 8'h00);
        for (int i = 0; i < 4; i++)
            u_cas_host_model.wr(8'h11 + 8'(i), 8'h00);
        chk_irq(1'b1);
        u_cas_host_model.wr(8'h0d, 8'hff);
        rdc(8'h0d, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            u_cas_host_model.wr(m_ofs[i], 8'hff);
            rdc(m_ofs[i], m_exp[i]);
        end
        live = 10'h3ff;
        @(negedge sys_clk);
        live = 10'h000;
        chk_irq(1'b1);
        for (int i = 0; i < 4; i++)
        begin
            u_cas_host_model.wr(m_ofs[i], 8'h00);
            chk_irq(1'b0);
            u_cas_host_model.wr(m_ofs[i], 8'hff);
            chk_irq(1'b1);
        end
        u_cas_host_model.wr(8'h11, 8'h02);
        u_cas_host_model.wr(8'h17, 8'hfd);
        chk_irq(1'b0);
        u_cas_host_model.wr(8'h17, 8'hde);
        chk_irq(1'b1);
        live = 10'h004;
        u_cas_host_model.wr(8'h11, 8'h00);
        rdc(8'h11, 8'h20);
        chk_irq(1'b0);
        live = 10'h000;
        nrst = 1'b0;
        rdc(8'h17, 8'h00);
        chk_irq(1'b1);
        nrst = 1'b1;
        repeat (3) @(negedge sys_clk);
        rdc(8'h11, 8'h00);
        rdc(8'h17, 8'h00);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
